// [excl_monitor.v]
`timescale 1ns/1ps
`include "stack_excl_consts.vh"
module excl_monitor
(
	input wire mclk,
	input wire srst,
	input wire set_en,
	input wire clr_en,
	input wire [31:0] set_addr,
	input wire [1:0] set_size,
	input wire [31:0] chk_addr,
	input wire [1:0] chk_size,
	input wire snoop_valid,
	input wire [31:0] snoop_addr,
	output wire pass,
	output wire armed
);
	reg armed_r;
	reg [31:0] addr_r;
	reg [1:0] size_r;
	assign armed = armed_r;
	// Snoop compares word granules to stay conservative for byte/half
	assign pass = armed_r && (addr_r == chk_addr) && (size_r == chk_size);
	always @(posedge mclk)
	begin
		if (srst)
		begin
			armed_r <= 1'b0;
			addr_r <= 32'h00000000;
			size_r <= 2'h0;
		end
		else if (set_en)
		begin
			armed_r <= 1'b1; // see (RQ18)
			addr_r <= set_addr;
			size_r <= set_size;
		end
		else if (clr_en)
			armed_r <= 1'b0; // see (RQ14)
		else if (snoop_valid && (snoop_addr[31:2] == addr_r[31:2]))
			armed_r <= 1'b0; // see (RQ13)
	end
endmodule

// [mem_model.sv]
`timescale 1ns/1ps
module mem_model
(
	input wire mclk,
	input wire mem_req,
	input wire mem_we,
	input wire [31:0] mem_addr,
	input wire [31:0] mem_wdata,
	input wire [1:0] lag,
	output reg mem_ack,
	output reg [31:0] mem_rdata
);
	reg [31:0] m [0:63];
	reg [1:0] w_r = 2'h0;
	initial mem_ack = 1'b0;
	initial mem_rdata = 32'h0;
	// Data toggles outside ack so stale sampling shows up
	always @(posedge mclk)
	begin
		mem_ack <= 1'b0;
		mem_rdata <= ~mem_rdata;
		if (mem_req && !mem_ack)
		begin
			w_r <= w_r + 2'h1;
			if (w_r == lag)
			begin
				w_r <= 2'h0;
				mem_ack <= 1'b1;
				mem_rdata <= m[mem_addr[7:2]];
				if (mem_we)
					m[mem_addr[7:2]] <= mem_wdata;
			end
		end
	end
endmodule

// [stack_excl_consts.vh]
`ifndef STACK_EXCL_CONSTS_VH
`define STACK_EXCL_CONSTS_VH
// Operation codes on the command port
`define OP_PUSH 3'h0
`define OP_POP 3'h1
`define OP_LDEX 3'h2
`define OP_STEX 3'h3
`define OP_CLEAR_EXCLUSIVE_MONITOR 3'h4
// Access sizes
`define SZ_BYTE 2'h0
`define SZ_HALF 2'h1
`define SZ_WORD 2'h2
// Register numbers with fixed roles
`define REG_SP 4'hd
`define REG_LR 4'he
`define REG_PC 4'hf
// Store-exclusive status values and bytes per word
`define STEX_OK 32'h00000000
`define STEX_FAIL 32'h00000001
`define WORD_BYTES 32'h00000004
`endif

// [stack_excl_properties.sv]
`timescale 1ns/1ps
`include "stack_excl_consts.vh"
module stack_excl_properties
(
	input wire mclk,
	input wire srst,
	input wire cmd_valid,
	input wire cmd_ready,
	input wire [2:0] cmd_op,
	input wire [1:0] cmd_size,
	input wire [31:0] stack_pointer,
	input wire [3:0] flags_in,
	input wire [3:0] flags_out,
	input wire mem_req,
	input wire mem_we,
	input wire [31:0] mem_addr,
	input wire [1:0] mem_size,
	input wire mem_ack,
	input wire wb_valid,
	input wire [31:0] wb_data,
	input wire branch_valid,
	input wire [31:0] branch_target,
	input wire done
);
	reg [2:0] op_r;
	reg [1:0] size_r;
	reg clr_r;
	wire take = cmd_valid && cmd_ready;
	always @(posedge mclk)
	begin
		if (take)
		begin
			op_r <= cmd_op;
			size_r <= cmd_size;
		end
		if (srst || take && cmd_op == `OP_LDEX)
			clr_r <= 1'b0;
		else if (take && cmd_op == `OP_CLEAR_EXCLUSIVE_MONITOR)
			clr_r <= 1'b1;
	end
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (srst);
	sequence push_step;
		mem_req && mem_ack && op_r == `OP_PUSH ##2 mem_req;
	endsequence
	a_flags_kept: assert property (flags_out == flags_in)
		else $error("flags changed");
	a_push_base: assert property (take && cmd_op == `OP_PUSH |-> ##2
		(mem_req && mem_addr == $past(stack_pointer, 2) - 32'h4))
		else $error("push base wrong");
	a_pop_base: assert property (take && cmd_op == `OP_POP |-> ##2
		(mem_req && mem_addr == $past(stack_pointer, 2)))
		else $error("pop base wrong");
	a_push_down: assert property (push_step |->
		mem_addr == $past(mem_addr, 2) - 32'h4)
		else $error("push not descending");
	a_branch_even: assert property (branch_valid |-> !branch_target[0])
		else $error("branch target odd");
	a_clear_fails: assert property (take && cmd_op == `OP_STEX && clr_r |=>
		done && wb_valid && wb_data == `STEX_FAIL && !mem_req)
		else $error("store after clear not failed");
	a_store_ok: assert property (mem_ack && mem_we && op_r == `OP_STEX |=>
		done && wb_valid && wb_data == `STEX_OK)
		else $error("stored but status not zero");
	a_ldex_size: assert property (mem_req && op_r == `OP_LDEX |->
		mem_size == size_r && !mem_we)
		else $error("load size wrong");
endmodule
bind stack_excl_unit stack_excl_properties chk_u (.*);

// [stack_excl_unit.v]
`timescale 1ns/1ps
`include "stack_excl_consts.vh"
// Contract
// (RQ1) Push stores highest register at highest address, walking downward.
// (RQ2) Pop loads lowest register from lowest address, walking upward.
// (RQ3) Stack pointer is base; final address written back to it.
// (RQ4) Software never gives an empty register list.
// (RQ5) Lists exclude stack pointer; push excludes PC; pop not PC with LR.
// (RQ6) Popped PC value needs bit 0 set; branch to halfword address.
// (RQ7) Conditional pop of PC sits last in its if-then block.
// (RQ8) None of these operations change the condition flags.
// (RQ9) Exclusive loads read word, byte or halfword as asked.
// (RQ10) Store-exclusive status is 0 when stored, 1 when not.
// (RQ11) Store-exclusive uses address of latest load-exclusive.
// (RQ12) Store-exclusive size matches preceding load-exclusive size.
// (RQ13) Success means no other agent touched the location meanwhile.
// (RQ14) After clear-exclusive the next store-exclusive fails, no write.
// (RQ15) No PC use; status differs from transfer and base registers.
// (RQ16) Word offset is a multiple of four, 0 to 1020.
// (RQ17) Keep code between load- and store-exclusive short.
// (RQ18) Local monitor holds address and size of latest load-exclusive.
module stack_excl_unit
(
	input wire mclk,
	input wire srst,
	input wire cmd_valid,
	output wire cmd_ready,
	input wire [2:0] cmd_op,
	input wire [15:0] cmd_reglist,
	input wire [1:0] cmd_size,
	input wire [31:0] cmd_addr,
	input wire [31:0] cmd_wdata,
	input wire [31:0] stack_pointer,
	input wire [3:0] flags_in,
	output reg [3:0] rd_idx,
	input wire [31:0] rd_data,
	output reg mem_req,
	output reg mem_we,
	output reg [31:0] mem_addr,
	output reg [1:0] mem_size,
	output reg [31:0] mem_wdata,
	input wire mem_ack,
	input wire [31:0] mem_rdata,
	input wire snoop_valid,
	input wire [31:0] snoop_addr,
	output reg wb_valid,
	output reg [3:0] wb_idx,
	output reg [31:0] wb_data,
	output reg sp_wb_valid,
	output reg [31:0] sp_wb_data,
	output reg branch_valid,
	output reg [31:0] branch_target,
	output reg branch_fault,
	output wire [3:0] flags_out,
	output wire monitor_armed,
	output reg done
);
	localparam ST_IDLE = 2'h0;
	localparam ST_MULTI = 2'h1;
	localparam ST_SINGLE = 2'h2;

	reg [1:0] state_r;
	reg [2:0] op_r;
	reg [15:0] list_r;
	reg [31:0] addr_r;
	reg [31:0] next_sp_r;
	wire [3:0] low_idx;
	wire [3:0] high_idx;
	wire [4:0] list_count;
	wire mon_pass;
	wire start;
	wire stex_go;
	reg mon_set;
	reg mon_clr;

	function [3:0] lowest;
		input [15:0] l;
		integer i;
		begin
			lowest = 4'h0;
			for (i = 15; i >= 0; i = i - 1)
				if (l[i])
					lowest = i[3:0];
		end
	endfunction

	function [3:0] highest;
		input [15:0] l;
		integer i;
		begin
			highest = 4'h0;
			for (i = 0; i < 16; i = i + 1)
				if (l[i])
					highest = i[3:0];
		end
	endfunction

	function [4:0] popcount;
		input [15:0] l;
		integer i;
		begin
			popcount = 5'h00;
			for (i = 0; i < 16; i = i + 1)
				popcount = popcount + {4'h0, l[i]};
		end
	endfunction

	// Flags pass straight through: nothing here writes them
	assign flags_out = flags_in; // see (RQ8)
	assign cmd_ready = (state_r == ST_IDLE);
	assign start = cmd_valid && cmd_ready;
	assign low_idx = lowest(list_r);
	assign high_idx = highest(list_r);
	assign list_count = popcount(cmd_reglist);
	assign stex_go = start && (cmd_op == `OP_STEX) && mon_pass;

	always @*
	begin
		rd_idx = 4'h0;
		if (state_r == ST_MULTI && op_r == `OP_PUSH)
			rd_idx = high_idx;
	end

	always @*
	begin
		mon_set = 1'b0;
		mon_clr = 1'b0;
		if (start && cmd_op == `OP_LDEX)
			mon_set = 1'b1; // see (RQ18)
		if (start && (cmd_op == `OP_STEX || cmd_op == `OP_CLEAR_EXCLUSIVE_MONITOR))
			mon_clr = 1'b1; // see (RQ14)
	end

	excl_monitor u_mon
	(
		.mclk(mclk),
		.srst(srst),
		.set_en(mon_set),
		.clr_en(mon_clr),
		.set_addr(cmd_addr),
		.set_size(cmd_size),
		.chk_addr(cmd_addr),
		.chk_size(cmd_size),
		.snoop_valid(snoop_valid),
		.snoop_addr(snoop_addr),
		.pass(mon_pass),
		.armed(monitor_armed)
	);

	always @(posedge mclk)
	begin
		if (srst)
		begin
			state_r <= ST_IDLE;
			op_r <= `OP_PUSH;
			list_r <= 16'h0000;
			addr_r <= 32'h00000000;
			next_sp_r <= 32'h00000000;
			mem_req <= 1'b0;
			mem_we <= 1'b0;
			mem_addr <= 32'h00000000;
			mem_size <= `SZ_WORD;
			mem_wdata <= 32'h00000000;
			wb_valid <= 1'b0;
			wb_idx <= 4'h0;
			wb_data <= 32'h00000000;
			sp_wb_valid <= 1'b0;
			sp_wb_data <= 32'h00000000;
			branch_valid <= 1'b0;
			branch_target <= 32'h00000000;
			branch_fault <= 1'b0;
			done <= 1'b0;
		end
		else
		begin
			wb_valid <= 1'b0;
			sp_wb_valid <= 1'b0;
			branch_valid <= 1'b0;
			branch_fault <= 1'b0;
			done <= 1'b0;
			case (state_r)
			ST_IDLE:
			begin
				if (start)
				begin
					op_r <= cmd_op;
					list_r <= cmd_reglist;
					case (cmd_op)
					`OP_PUSH:
					begin
						// Lowest slot is SP minus four per register
						next_sp_r <= stack_pointer - {25'h0, list_count, 2'h0}; // see (RQ3)
						addr_r <= stack_pointer - `WORD_BYTES;
						state_r <= ST_MULTI;
					end
					`OP_POP:
					begin
						// Last slot read is SP plus four per extra register
						next_sp_r <= stack_pointer +
							{25'h0, list_count, 2'h0} - `WORD_BYTES; // see (RQ3)
						addr_r <= stack_pointer;
						state_r <= ST_MULTI;
					end
					`OP_LDEX:
					begin
						mem_req <= 1'b1;
						mem_we <= 1'b0;
						mem_addr <= cmd_addr;
						mem_size <= cmd_size; // see (RQ9)
						state_r <= ST_SINGLE;
					end
					`OP_STEX:
					begin
						if (stex_go)
						begin
							mem_req <= 1'b1;
							mem_we <= 1'b1;
							mem_addr <= cmd_addr;
							mem_size <= cmd_size;
							mem_wdata <= cmd_wdata;
							state_r <= ST_SINGLE;
						end
						else
						begin
							// Failed attempt never reaches memory
							wb_valid <= 1'b1;
							wb_data <= `STEX_FAIL; // see (RQ10)
							done <= 1'b1;
						end
					end
					default:
						done <= 1'b1;
					endcase
				end
			end
			ST_MULTI:
			begin
				if (!mem_req)
				begin
					mem_req <= 1'b1;
					mem_size <= `SZ_WORD;
					mem_addr <= addr_r;
					mem_we <= (op_r == `OP_PUSH);
					mem_wdata <= rd_data; // see (RQ1)
				end
				else if (mem_ack)
				begin
					mem_req <= 1'b0;
					if (op_r == `OP_PUSH)
					begin
						list_r[high_idx] <= 1'b0; // see (RQ1)
						addr_r <= addr_r - `WORD_BYTES;
					end
					else
					begin
						list_r[low_idx] <= 1'b0; // see (RQ2)
						addr_r <= addr_r + `WORD_BYTES;
						if (low_idx == `REG_PC)
						begin
							branch_valid <= 1'b1; // see (RQ6)
							branch_target <= {mem_rdata[31:1], 1'b0};
							branch_fault <= ~mem_rdata[0];
						end
						else
						begin
							wb_valid <= 1'b1;
							wb_idx <= low_idx;
							wb_data <= mem_rdata;
						end
					end
					if (list_r == (16'h0001 << (op_r == `OP_PUSH ? high_idx :
						low_idx)))
					begin
						sp_wb_valid <= 1'b1; // see (RQ3)
						sp_wb_data <= next_sp_r;
						done <= 1'b1;
						state_r <= ST_IDLE;
					end
				end
			end
			ST_SINGLE:
			begin
				if (mem_ack)
				begin
					mem_req <= 1'b0;
					wb_valid <= 1'b1;
					if (op_r == `OP_LDEX)
						wb_data <= mem_rdata;
					else
						wb_data <= `STEX_OK; // see (RQ10)
					done <= 1'b1;
					state_r <= ST_IDLE;
				end
			end
			default:
				state_r <= ST_IDLE;
			endcase
		end
	end
endmodule

// [tb.sv]
`timescale 1ns/1ps
`include "stack_excl_consts.vh"
module tb;
	reg mclk = 1'b0;
	reg srst = 1'b1;
	reg cmd_valid = 1'b0;
	reg [2:0] cmd_op = 3'h0;
	reg [15:0] cmd_reglist = 16'h0;
	reg [1:0] cmd_size = 2'h0;
	reg [31:0] cmd_addr = 32'h0;
	reg [31:0] cmd_wdata = 32'h0;
	reg [31:0] stack_pointer = 32'h100;
	reg [3:0] flags_in = 4'h9;
	reg snoop_valid = 1'b0;
	reg [31:0] snoop_addr = 32'h40;
	reg [1:0] lag = 2'h1;
	wire cmd_ready, mem_req, mem_we, mem_ack, wb_valid, sp_wb_valid;
	wire branch_valid, branch_fault, monitor_armed, done;
	wire [3:0] rd_idx, wb_idx, flags_out;
	wire [1:0] mem_size;
	wire [31:0] mem_addr, mem_wdata, mem_rdata, wb_data, sp_wb_data;
	wire [31:0] branch_target;
	wire [31:0] rd_data = {28'ha000000, rd_idx};
	reg [31:0] regs [0:15];
	reg [31:0] sp_r, st_r, br_r;
	reg bf_r;
	integer errors = 0;
	integer n_tests = 0;
	integer cyc = 0;
	integer s;
	`define CHK(a, e) begin n_tests = n_tests + 1; if ((a) !== (e)) \
		begin errors = errors + 1; \
		$display("MISMATCH %0t got %h want %h", $time, a, e); end end
	stack_excl_unit dut_u (.*);
	mem_model mem_u (.*);
	always #5 mclk = ~mclk;
	always @(posedge mclk)
	begin
		cyc <= cyc + 1;
		if (wb_valid)
		begin
			regs[wb_idx] <= wb_data;
			st_r <= wb_data;
		end
		if (sp_wb_valid)
			sp_r <= sp_wb_data;
		// Fault stands one cycle only, so keep it for the checks
		if (branch_valid)
		begin
			br_r <= branch_target;
			bf_r <= branch_fault;
		end
		if (cyc == 3000)
		begin
			errors = errors + 1;
			wrap_up;
		end
	end
	task wrap_up;
		begin
			$display("errors=%0d n_tests=%0d", errors, n_tests);
			if (errors == 0 && n_tests > 0)
				$display("STATUS OK");
			else
				$display("STATUS NOT OK");
			$finish;
		end
	endtask
	task cmd(input [2:0] op, input [15:0] l, input [1:0] sz);
		integer k;
		begin
			@(negedge mclk);
			cmd_op = op;
			cmd_reglist = l;
			cmd_size = sz;
			cmd_valid = 1'b1;
			// Ready moves on rising edges only; falling edge shows next take
			while (cmd_ready !== 1'b1)
				@(negedge mclk);
			@(posedge mclk);
			@(negedge mclk);
			cmd_valid = 1'b0;
			for (k = 0; k < 100 && done !== 1'b1; k = k + 1)
				@(negedge mclk);
			`CHK(done, 1'b1)
			// Let the result pulses be captured before the checks
			@(negedge mclk);
		end
	endtask
	task t_stack;
		begin
			cmd(`OP_PUSH, 16'h4011, `SZ_WORD);
			`CHK(mem_u.m[63], 32'ha000000e)
			`CHK(mem_u.m[62], 32'ha0000004)
			`CHK(mem_u.m[61], 32'ha0000000)
			`CHK(sp_r, 32'hf4)
			`CHK(flags_out, 4'h9)
			mem_u.m[63] = 32'h201;
			stack_pointer = 32'hf4;
			lag = 2'h0;
			cmd(`OP_POP, 16'h8011, `SZ_WORD);
			`CHK(regs[0], 32'ha0000000)
			`CHK(regs[4], 32'ha0000004)
			`CHK(br_r, 32'h200)
			`CHK(bf_r, 1'b0)
			`CHK(sp_r, 32'hfc)
			mem_u.m[63] = 32'h300;
			stack_pointer = 32'hfc;
			cmd(`OP_POP, 16'h8000, `SZ_WORD);
			`CHK(br_r, 32'h300)
			`CHK(bf_r, 1'b1)
			`CHK(sp_r, 32'hfc)
		end
	endtask
	task t_excl;
		begin
			cmd_addr = 32'h40;
			flags_in = 4'h6;
			for (s = 0; s < 3; s = s + 1)
			begin
				cmd_wdata = 32'h5a5a0000 | s;
				cmd(`OP_LDEX, 16'h0, s[1:0]);
				`CHK(monitor_armed, 1'b1)
				cmd(`OP_STEX, 16'h0, s[1:0]);
				`CHK(st_r, `STEX_OK)
				`CHK(monitor_armed, 1'b0)
			end
			`CHK(flags_out, 4'h6)
			`CHK(mem_u.m[16], 32'h5a5a0002)
			cmd(`OP_LDEX, 16'h0, `SZ_WORD);
			`CHK(st_r, 32'h5a5a0002)
			cmd(`OP_CLEAR_EXCLUSIVE_MONITOR, 16'h0, `SZ_WORD);
			`CHK(monitor_armed, 1'b0)
			cmd_wdata = 32'h0bad0001;
			cmd(`OP_STEX, 16'h0, `SZ_WORD);
			`CHK(st_r, `STEX_FAIL)
			cmd(`OP_LDEX, 16'h0, `SZ_WORD);
			snoop_valid = 1'b1;
			@(negedge mclk);
			snoop_valid = 1'b0;
			`CHK(monitor_armed, 1'b0)
			cmd(`OP_STEX, 16'h0, `SZ_WORD);
			`CHK(st_r, `STEX_FAIL)
			`CHK(mem_u.m[16], 32'h5a5a0002)
		end
	endtask
	initial
	begin
		mem_u.m[16] = 32'h12345678;
		repeat (10) @(posedge mclk);
		@(negedge mclk);
		srst = 1'b0;
		t_stack;
		t_excl;
		wrap_up;
	end
endmodule
